// *** logic/cpu_flags_map.svh ***
// Bit positions, vectors and fixed values of the CPU control state.
`ifndef CPU_FLAGS_MAP_SVH
`define CPU_FLAGS_MAP_SVH

// ----------------------------------------------------------------
// Condition flags bit positions
// ----------------------------------------------------------------
`define FLAG_MASK_BIT 7
`define FLAG_USER_HI_BIT 6
`define FLAG_HALF_BIT 5
`define FLAG_USER_LO_BIT 4
`define FLAG_SIGN_BIT 3
`define FLAG_ZERO_BIT 2
`define FLAG_OVFL_BIT 1
`define FLAG_CARRY_BIT 0

// ----------------------------------------------------------------
// Arithmetic carry positions, reset values and word address step and mask
// ----------------------------------------------------------------
`define HALF_BYTE_BIT 4
`define HALF_WORD_BIT 12
`define RESET_VECTOR_ADDR 16'h0000
`define RESET_MASK_VALUE 1'b1
`define RESET_POINTER_VALUE 16'h0000
`define WORD_STEP 16'h0002
`define EVEN_ADDR_MASK 16'hfffe

`endif

// *** logic/cpu_flags_pkg.sv ***
// Types shared by the CPU flag core and its execution units.
package cpu_flags_pkg;

    typedef enum logic [4:0] {
        OP_NOP, OP_ADD, OP_ADDX, OP_SUB, OP_SUBX, OP_CMP, OP_NEG,
        OP_SHLL, OP_SHLR, OP_ROTXL, OP_ROTXR, OP_MOVE,
        OP_BLD, OP_BST, OP_BAND, OP_BOR, OP_BXOR,
        OP_BSET, OP_BCLR, OP_BNOT, OP_BTST,
        OP_DAA, OP_DAS, OP_LDC, OP_STC, OP_MASK_FLAGS_OP, OP_ORC, OP_TOGGLE_FLAGS_OP,
        OP_RTE
    } op_kind_t;

    typedef enum logic [3:0] {
        CC_ALWAYS, CC_NEVER, CC_HI, CC_LS, CC_CARRY_CLR, CC_CARRY_SET,
        CC_NE, CC_EQ, CC_VC, CC_VS, CC_PL, CC_MI, CC_GE, CC_LT,
        CC_GT, CC_LE
    } cond_t;

    typedef enum logic [2:0] {
        ST_VEC_READ, ST_RUN, ST_PUSH_PC, ST_PUSH_FLAGS, ST_EXC_VEC,
        ST_POP_FLAGS, ST_POP_PC
    } core_state_t;

    typedef struct packed {
        core_state_t st;
        logic [15:0] pc;
        logic [15:0] sp;
        logic [7:0] flags;
        logic [7:0] saved;
        logic [15:0] res;
        logic done;
    } core_reg_t;

endpackage : cpu_flags_pkg

// *** logic/exec_bus_if.sv ***
// Operand and result bundle between the core and its execution units.
`timescale 1ns/100ps
interface exec_bus_if;
    import cpu_flags_pkg::*;
    op_kind_t kind;
    logic word;
    logic [15:0] a;
    logic [15:0] b;
    logic [2:0] bitn;
    logic c_in;
    logic h_in;
    logic [15:0] ar_res;
    logic ar_h, ar_n, ar_z, ar_v, ar_c;
    logic [7:0] bb_res;
    logic bb_c, bb_z;

    modport core (output kind, word, a, b, bitn, c_in, h_in,
                  input ar_res, ar_h, ar_n, ar_z, ar_v, ar_c,
                  input bb_res, bb_c, bb_z);
    modport arith (input kind, word, a, b, c_in,
                   output ar_res, ar_h, ar_n, ar_z, ar_v, ar_c);
    modport bitbcd (input kind, a, bitn, c_in, h_in,
                    output bb_res, bb_c, bb_z);
endinterface : exec_bus_if

// *** logic/arith_unit.sv ***
// Byte and word add, subtract, compare and negate, and byte shift and rotate, with flags.
`timescale 1ns/100ps
`include "cpu_flags_map.svh"
module arith_unit
    import cpu_flags_pkg::*;
(
    exec_bus_if.arith bus
);
    logic sub, ext, ci, co, sx, sy, sr;
    logic [15:0] x, y;
    logic [8:0] s9;
    logic [16:0] s17;
    logic [`HALF_BYTE_BIT:0] hb;
    logic [`HALF_WORD_BIT:0] hw;

    always_comb begin
        sub = bus.kind inside {OP_SUB, OP_SUBX, OP_CMP, OP_NEG};
        ext = bus.kind inside {OP_ADDX, OP_SUBX};
        x = (bus.kind == OP_NEG) ? 16'h0000 : bus.a;
        y = (bus.kind == OP_NEG) ? ~bus.a : (sub ? ~bus.b : bus.b);
        ci = ext ? (bus.c_in ^ sub) : sub;
        s9 = {1'b0, x[7:0]} + {1'b0, y[7:0]} + {8'h00, ci};
        s17 = {1'b0, x} + {1'b0, y} + {16'h0000, ci};
        hb = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
        hw = {1'b0, x[11:0]} + {1'b0, y[11:0]} + {12'h000, ci};
        bus.ar_res = bus.word ? s17[15:0] : {8'h00, s9[7:0]};
        co = bus.word ? s17[16] : s9[8];
        bus.ar_c = co ^ sub; // RULE_10
        bus.ar_h = (bus.word ? hw[`HALF_WORD_BIT] // RULE_06
                             : hb[`HALF_BYTE_BIT]) ^ sub; // RULE_05
        sx = bus.word ? x[15] : x[7];
        sy = bus.word ? y[15] : y[7];
        sr = bus.word ? bus.ar_res[15] : bus.ar_res[7];
        bus.ar_v = (sx == sy) && (sr != sx); // RULE_09
        case (bus.kind)
            OP_SHLL: begin
                bus.ar_res = {8'h00, bus.a[6:0], 1'b0};
                bus.ar_c = bus.a[7]; // RULE_10
                bus.ar_v = 1'b0;
            end
            OP_SHLR: begin
                bus.ar_res = {8'h00, 1'b0, bus.a[7:1]};
                bus.ar_c = bus.a[0]; // RULE_10
                bus.ar_v = 1'b0;
            end
            OP_ROTXL: begin
                bus.ar_res = {8'h00, bus.a[6:0], bus.c_in};
                bus.ar_c = bus.a[7];
                bus.ar_v = 1'b0;
            end
            OP_ROTXR: begin
                bus.ar_res = {8'h00, bus.c_in, bus.a[7:1]};
                bus.ar_c = bus.a[0];
                bus.ar_v = 1'b0;
            end
            default: begin
            end
        endcase
        bus.ar_n = bus.word ? bus.ar_res[15] : bus.ar_res[7]; // RULE_07
        bus.ar_z = bus.word ? (bus.ar_res == 16'h0000) // RULE_08
                            : (bus.ar_res[7:0] == 8'h00);
    end
endmodule : arith_unit

// *** logic/bit_bcd_unit.sv ***
// Single-bit operations on a byte and packed decimal adjustment.
`timescale 1ns/100ps
module bit_bcd_unit
    import cpu_flags_pkg::*;
(
    exec_bus_if.bitbcd bus
);
    logic sel, newbit;
    logic [7:0] ins, adj;

    always_comb begin
        sel = bus.a[bus.bitn]; // RULE_17
        case (bus.kind)
            OP_BST: newbit = bus.c_in;
            OP_BSET: newbit = 1'b1;
            OP_BNOT: newbit = ~sel;
            default: newbit = 1'b0;
        endcase
    end

    for (genvar i = 0; i < 8; i++) begin : g_bit
        assign ins[i] = (bus.bitn == 3'(i)) ? newbit : bus.a[i]; // RULE_17
    end

    always_comb begin
        adj = 8'h00;
        bus.bb_c = bus.c_in;
        bus.bb_res = bus.a[7:0];
        case (bus.kind)
            OP_BLD: bus.bb_c = sel; // RULE_11
            OP_BAND: bus.bb_c = bus.c_in & sel; // RULE_11
            OP_BOR: bus.bb_c = bus.c_in | sel; // RULE_11
            OP_BXOR: bus.bb_c = bus.c_in ^ sel; // RULE_11
            OP_BST, OP_BSET, OP_BCLR, OP_BNOT: bus.bb_res = ins;
            OP_DAA: begin
                if (bus.h_in || (bus.a[3:0] > 4'h9)) begin // RULE_18
                    adj[3:0] = 4'h6;
                end
                if (bus.c_in || (bus.a[7:0] > 8'h99)) begin
                    adj[7:4] = 4'h6;
                    bus.bb_c = 1'b1;
                end
                bus.bb_res = bus.a[7:0] + adj;
            end
            OP_DAS: begin
                adj = {bus.c_in ? 4'h6 : 4'h0, // RULE_18
                       bus.h_in ? 4'h6 : 4'h0};
                bus.bb_res = bus.a[7:0] - adj;
            end
            default: begin
            end
        endcase
        bus.bb_z = (bus.kind == OP_BTST) ? ~sel : (bus.bb_res == 8'h00);
    end
endmodule : bit_bcd_unit

// *** logic/cpu_flags_core.sv ***
// CPU control state: program counter, condition flags and stacking.
//
// Overview of operation
// RULE_01: 16-bit program counter, lowest bit always zero.
// RULE_02: Mask bit 7 set blocks interrupts; software-accessible.
// RULE_03: Exception entry sets the mask bit.
// RULE_04: Bits 6 and 4 are plain user bits.
// RULE_05: Byte arithmetic half-carry from bit 3.
// RULE_06: Word arithmetic half-carry from bit 11.
// RULE_07: Sign flag copies the result's top bit.
// RULE_08: Zero flag marks an all-zero result.
// RULE_09: Overflow flag marks arithmetic overflow only.
// RULE_10: Carry holds add carry, borrow, shifted-out bit.
// RULE_11: Carry serves as the bit accumulator.
// RULE_12: Load, store, AND, OR, XOR the flags.
// RULE_13: Branch conditions use sign, zero, overflow, carry.
// RULE_14: Reset loads counter from vector 0, sets mask.
// RULE_15: Reset leaves other flags and pointer unset.
// RULE_16: Software sets the stack pointer first thing.
// RULE_17: Bit operations select bit 0..7 of a byte.
// RULE_18: Decimal adjust works per nibble using half-carry.
// RULE_19: Word accesses and fetches use even addresses.
// RULE_20: Software keeps word accesses to ROM and RAM.
// RULE_21: Software uses word accesses on the stack.
// RULE_22: Flags stacked twice; restore takes upper byte.
// RULE_23: Stack pointer drives exception and return stacking.
// RULE_24: Words stored upper byte at even address.
`timescale 1ns/100ps
`include "cpu_flags_map.svh"
module cpu_flags_core
    import cpu_flags_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Operation request and answer
    input wire logic op_valid,
    input wire op_kind_t op_kind,
    input wire logic op_word,
    input wire logic [15:0] op_a,
    input wire logic [15:0] op_b,
    input wire logic [2:0] op_bitn,
    output logic op_ready,
    output logic op_done,
    output logic [15:0] op_result,
    // Condition flags and branch test
    output logic [7:0] condition_flags,
    input wire cond_t cond_sel,
    output logic cond_true,
    // Program counter control
    input wire logic pc_step,
    input wire logic pc_load,
    input wire logic [15:0] pc_target,
    output logic [15:0] next_instruction_pointer,
    // Stack pointer control
    input wire logic sp_load,
    input wire logic [15:0] sp_value,
    output logic [15:0] stack_top_pointer,
    // Exception entry
    input wire logic exc_req,
    input wire logic exc_nmi,
    input wire logic [15:0] exc_vector,
    output logic irq_masked,
    output logic exc_taken,
    // Word memory port
    output logic mem_req,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack
);

    // ------------------------------------------------------------
    // State and execution units
    // ------------------------------------------------------------
    core_reg_t r_reg;
    core_reg_t r_next;
    logic take_exc;
    logic ni, zi, vi, ci;

    exec_bus_if ebus ();

    arith_unit u_arith (
        .bus(ebus.arith)
    );

    bit_bcd_unit u_bitbcd (
        .bus(ebus.bitbcd)
    );

    assign ebus.kind = op_kind;
    assign ebus.word = op_word;
    assign ebus.a = op_a;
    assign ebus.b = op_b;
    assign ebus.bitn = op_bitn;
    assign ebus.c_in = r_reg.flags[`FLAG_CARRY_BIT];
    assign ebus.h_in = r_reg.flags[`FLAG_HALF_BIT];

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign condition_flags = r_reg.flags;
    assign next_instruction_pointer = r_reg.pc;
    assign stack_top_pointer = r_reg.sp;
    assign op_result = r_reg.res;
    assign op_done = r_reg.done;
    assign op_ready = (r_reg.st == ST_RUN);
    assign irq_masked = r_reg.flags[`FLAG_MASK_BIT]; // RULE_02
    assign take_exc = (r_reg.st == ST_RUN) && !op_valid
                      && ((exc_req && !irq_masked) || exc_nmi); // RULE_02
    assign exc_taken = take_exc;

    // ------------------------------------------------------------
    // Branch condition test
    // ------------------------------------------------------------
    assign ni = r_reg.flags[`FLAG_SIGN_BIT];
    assign zi = r_reg.flags[`FLAG_ZERO_BIT];
    assign vi = r_reg.flags[`FLAG_OVFL_BIT];
    assign ci = r_reg.flags[`FLAG_CARRY_BIT];

    always_comb begin
        case (cond_sel) // RULE_13
            CC_ALWAYS: cond_true = 1'b1;
            CC_NEVER: cond_true = 1'b0;
            CC_HI: cond_true = !(ci || zi);
            CC_LS: cond_true = ci || zi;
            CC_CARRY_CLR: cond_true = !ci;
            CC_CARRY_SET: cond_true = ci;
            CC_NE: cond_true = !zi;
            CC_EQ: cond_true = zi;
            CC_VC: cond_true = !vi;
            CC_VS: cond_true = vi;
            CC_PL: cond_true = !ni;
            CC_MI: cond_true = ni;
            CC_GE: cond_true = !(ni ^ vi);
            CC_LT: cond_true = ni ^ vi;
            CC_GT: cond_true = !(zi || (ni ^ vi));
            CC_LE: cond_true = zi || (ni ^ vi);
            default: cond_true = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Memory port
    // ------------------------------------------------------------
    always_comb begin
        mem_req = 1'b1;
        mem_we = 1'b0;
        mem_wdata = 16'h0000;
        mem_addr = r_reg.sp;
        case (r_reg.st)
            ST_VEC_READ: mem_addr = `RESET_VECTOR_ADDR; // RULE_14
            ST_PUSH_PC: begin
                mem_we = 1'b1;
                mem_addr = r_reg.sp - `WORD_STEP; // RULE_23
                mem_wdata = r_reg.pc; // RULE_24
            end
            ST_PUSH_FLAGS: begin
                mem_we = 1'b1;
                mem_addr = r_reg.sp - `WORD_STEP;
                mem_wdata = {r_reg.saved, r_reg.saved}; // RULE_22
            end
            ST_EXC_VEC: mem_addr = exc_vector;
            ST_POP_FLAGS, ST_POP_PC: mem_addr = r_reg.sp; // RULE_23
            default: mem_req = 1'b0;
        endcase
        mem_addr = mem_addr & `EVEN_ADDR_MASK; // RULE_19
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        r_next = r_reg;
        r_next.done = 1'b0;
        case (r_reg.st)
            ST_VEC_READ: begin
                if (mem_ack) begin
                    r_next.pc = mem_rdata & `EVEN_ADDR_MASK; // RULE_14
                    r_next.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (pc_load) begin
                    r_next.pc = pc_target & `EVEN_ADDR_MASK; // RULE_01
                end else if (pc_step) begin
                    r_next.pc = r_reg.pc + `WORD_STEP; // RULE_01
                end
                if (sp_load) begin
                    r_next.sp = sp_value;
                end
                if (op_valid) begin
                    r_next.done = 1'b1;
                    r_next.res = op_a;
                    case (op_kind)
                        OP_ADD, OP_ADDX, OP_SUB, OP_SUBX, OP_NEG: begin
                            r_next.res = ebus.ar_res;
                            r_next.flags[`FLAG_HALF_BIT] = ebus.ar_h;
                            r_next.flags[`FLAG_SIGN_BIT] = ebus.ar_n;
                            r_next.flags[`FLAG_ZERO_BIT] = ebus.ar_z;
                            r_next.flags[`FLAG_OVFL_BIT] = ebus.ar_v;
                            r_next.flags[`FLAG_CARRY_BIT] = ebus.ar_c;
                        end
                        OP_CMP: begin
                            r_next.flags[`FLAG_HALF_BIT] = ebus.ar_h;
                            r_next.flags[`FLAG_SIGN_BIT] = ebus.ar_n;
                            r_next.flags[`FLAG_ZERO_BIT] = ebus.ar_z;
                            r_next.flags[`FLAG_OVFL_BIT] = ebus.ar_v;
                            r_next.flags[`FLAG_CARRY_BIT] = ebus.ar_c;
                        end
                        OP_SHLL, OP_SHLR, OP_ROTXL, OP_ROTXR: begin
                            r_next.res = ebus.ar_res;
                            r_next.flags[`FLAG_SIGN_BIT] = ebus.ar_n;
                            r_next.flags[`FLAG_ZERO_BIT] = ebus.ar_z;
                            r_next.flags[`FLAG_OVFL_BIT] = 1'b0;
                            r_next.flags[`FLAG_CARRY_BIT] = ebus.ar_c;
                        end
                        OP_MOVE: begin
                            r_next.flags[`FLAG_SIGN_BIT] = ebus.ar_n;
                            r_next.flags[`FLAG_ZERO_BIT] = op_word
                                ? (op_a == 16'h0000) // RULE_08
                                : (op_a[7:0] == 8'h00);
                            r_next.flags[`FLAG_SIGN_BIT] = op_word
                                ? op_a[15] : op_a[7]; // RULE_07
                            r_next.flags[`FLAG_OVFL_BIT] = 1'b0;
                        end
                        OP_BLD, OP_BAND, OP_BOR, OP_BXOR: begin
                            r_next.flags[`FLAG_CARRY_BIT] = ebus.bb_c;
                        end
                        OP_BST, OP_BSET, OP_BCLR, OP_BNOT: begin
                            r_next.res = {8'h00, ebus.bb_res};
                        end
                        OP_BTST: begin
                            r_next.flags[`FLAG_ZERO_BIT] = ebus.bb_z;
                        end
                        OP_DAA, OP_DAS: begin
                            r_next.res = {8'h00, ebus.bb_res};
                            r_next.flags[`FLAG_SIGN_BIT] = ebus.bb_res[7];
                            r_next.flags[`FLAG_ZERO_BIT] = ebus.bb_z;
                            r_next.flags[`FLAG_CARRY_BIT] = ebus.bb_c;
                        end
                        OP_LDC: r_next.flags = op_a[7:0]; // RULE_12 RULE_04
                        OP_STC: r_next.res = {8'h00, r_reg.flags}; // RULE_12
                        OP_MASK_FLAGS_OP: r_next.flags = r_reg.flags & op_a[7:0]; // RULE_12
                        OP_ORC: r_next.flags = r_reg.flags | op_a[7:0]; // RULE_12
                        OP_TOGGLE_FLAGS_OP: r_next.flags = r_reg.flags ^ op_a[7:0]; // RULE_12
                        OP_RTE: begin
                            r_next.done = 1'b0;
                            r_next.st = ST_POP_FLAGS;
                        end
                        default: begin
                        end
                    endcase
                end else if (take_exc) begin
                    r_next.saved = r_reg.flags;
                    r_next.flags[`FLAG_MASK_BIT] = 1'b1; // RULE_03
                    r_next.st = ST_PUSH_PC;
                end
            end
            ST_PUSH_PC: begin
                if (mem_ack) begin
                    r_next.sp = r_reg.sp - `WORD_STEP; // RULE_23
                    r_next.st = ST_PUSH_FLAGS;
                end
            end
            ST_PUSH_FLAGS: begin
                if (mem_ack) begin
                    r_next.sp = r_reg.sp - `WORD_STEP;
                    r_next.st = ST_EXC_VEC;
                end
            end
            ST_EXC_VEC: begin
                if (mem_ack) begin
                    r_next.pc = mem_rdata & `EVEN_ADDR_MASK; // RULE_01
                    r_next.st = ST_RUN;
                end
            end
            ST_POP_FLAGS: begin
                if (mem_ack) begin
                    r_next.flags = mem_rdata[15:8]; // RULE_22
                    r_next.sp = r_reg.sp + `WORD_STEP;
                    r_next.st = ST_POP_PC;
                end
            end
            ST_POP_PC: begin
                if (mem_ack) begin
                    r_next.pc = mem_rdata & `EVEN_ADDR_MASK;
                    r_next.sp = r_reg.sp + `WORD_STEP;
                    r_next.done = 1'b1;
                    r_next.st = ST_RUN;
                end
            end
            default: r_next.st = ST_RUN;
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            r_reg.st <= ST_VEC_READ; // RULE_14
            r_reg.flags[`FLAG_MASK_BIT] <= `RESET_MASK_VALUE; // RULE_14
            r_reg.pc <= `RESET_POINTER_VALUE;
            r_reg.res <= 16'h0000;
            r_reg.done <= 1'b0;
        end else begin
            r_reg <= r_next; // RULE_15
        end
    end

endmodule : cpu_flags_core

// *** testbench/cpu_flags_core_sva.sv ***
// Concurrent checks on the ports of the CPU control state core.
`timescale 1ns/100ps
module cpu_flags_core_sva
    import cpu_flags_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Watched ports
    input wire logic op_valid,
    input wire op_kind_t op_kind,
    input wire logic op_ready,
    input wire logic op_done,
    input wire logic [7:0] condition_flags,
    input wire cond_t cond_sel,
    input wire logic cond_true,
    input wire logic [15:0] next_instruction_pointer,
    input wire logic [15:0] stack_top_pointer,
    input wire logic exc_req,
    input wire logic exc_nmi,
    input wire logic irq_masked,
    input wire logic exc_taken,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr
);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_pc_even: assert property (
        next_instruction_pointer[0] == 1'b0) else $error("odd pc");
    a_addr_even: assert property (
        mem_req |-> mem_addr[0] == 1'b0) else $error("odd address");
    a_reset_fetch: assert property (
        $rose(rst_n) |-> condition_flags[7] && mem_req
        && mem_addr == 16'h0000) else $error("bad reset fetch");
    a_entry_mask: assert property (
        exc_taken |=> condition_flags[7]) else $error("mask not set");
    a_mask_gate: assert property (
        exc_taken |-> !op_valid && (exc_nmi || exc_req
        && !condition_flags[7])) else $error("masked entry");
    a_mask_view: assert property (
        irq_masked == condition_flags[7]) else $error("mask mismatch");
    a_op_answer: assert property (
        op_valid && op_ready && op_kind != OP_RTE |=> op_done)
        else $error("no done");
    a_branch_zero: assert property (
        cond_sel == CC_EQ |-> cond_true == condition_flags[2])
        else $error("bad branch test");
    a_push_first: assert property (
        exc_taken |=> mem_req && mem_we
        && mem_addr == stack_top_pointer - 16'h0002)
        else $error("bad first push");
endmodule : cpu_flags_core_sva

// *** testbench/cpu_flags_core_bench.sv ***
// Self-checking bench for the CPU control state core.
`timescale 1ns/100ps
module cpu_flags_core_bench
    import cpu_flags_pkg::*;
;
    typedef struct {
        op_kind_t k;
        logic w;
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] r;
        logic [7:0] f;
    } row_t;
    logic sys_clk = 1'b0, rst_n = 1'b0, op_valid = 1'b0, op_word = 1'b0;
    logic pc_step = 1'b0, pc_load = 1'b0, sp_load = 1'b0, exc_req = 1'b0;
    logic mem_ack = 1'b0, seen = 1'b0;
    logic [15:0] op_a = 16'h0, op_b = 16'h0, pc_target = 16'h0;
    logic [15:0] sp_value = 16'h0, exc_vector = 16'h0, mem_rdata = 16'h0;
    logic [2:0] op_bitn = 3'h0;
    op_kind_t op_kind = OP_NOP;
    cond_t cond_sel = CC_ALWAYS;
    logic op_ready, op_done, cond_true, exc_taken, mem_req, mem_we;
    logic [15:0] op_result, next_instruction_pointer, stack_top_pointer;
    logic [15:0] mem_addr, mem_wdata, m;
    logic [7:0] condition_flags;
    logic [15:0] mem [0:2047];
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    cond_t cs [4] = '{CC_MI, CC_EQ, CC_VS, CC_CARRY_SET};
    logic ce [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    row_t rows [20] = '{
        '{OP_LDC, 1'b0, 16'h50, 16'h0, 16'h50, 8'h50},
        '{OP_ADD, 1'b0, 16'h0f, 16'h1, 16'h10, 8'h70},
        '{OP_ADD, 1'b0, 16'hff, 16'h1, 16'h00, 8'h75},
        '{OP_SUB, 1'b0, 16'h00, 16'h1, 16'hff, 8'h79},
        '{OP_CMP, 1'b0, 16'h80, 16'h1, 16'h80, 8'h72},
        '{OP_NEG, 1'b0, 16'h01, 16'h0, 16'hff, 8'h79},
        '{OP_ADD, 1'b1, 16'h0fff, 16'h1, 16'h1000, 8'h70},
        '{OP_SUB, 1'b1, 16'h8000, 16'h1, 16'h7fff, 8'h72},
        '{OP_SHLL, 1'b0, 16'h81, 16'h0, 16'h02, 8'h71},
        '{OP_SHLR, 1'b0, 16'h01, 16'h0, 16'h00, 8'h75},
        '{OP_BLD, 1'b0, 16'h7f, 16'h7, 16'h7f, 8'h74},
        '{OP_BST, 1'b0, 16'hff, 16'h0, 16'hfe, 8'h74},
        '{OP_MASK_FLAGS_OP, 1'b0, 16'h0f, 16'h0, 16'h0f, 8'h04},
        '{OP_ORC, 1'b0, 16'hc0, 16'h0, 16'hc0, 8'hc4},
        '{OP_TOGGLE_FLAGS_OP, 1'b0, 16'h41, 16'h0, 16'h41, 8'h85},
        '{OP_STC, 1'b0, 16'h00, 16'h0, 16'h85, 8'h85},
        '{OP_ADD, 1'b0, 16'h09, 16'h1, 16'h0a, 8'h80},
        '{OP_DAA, 1'b0, 16'h0a, 16'h0, 16'h10, 8'h80},
        '{OP_MOVE, 1'b1, 16'h8000, 16'h0, 16'h8000, 8'h88},
        '{OP_BTST, 1'b0, 16'h04, 16'h3, 16'h04, 8'h8c}
    };

    cpu_flags_core dut (
        .sys_clk, .rst_n, .op_valid, .op_kind, .op_word, .op_a, .op_b,
        .op_bitn, .op_ready, .op_done, .op_result, .condition_flags,
        .cond_sel, .cond_true, .pc_step, .pc_load, .pc_target,
        .next_instruction_pointer, .sp_load, .sp_value,
        .stack_top_pointer, .exc_req, .exc_nmi(1'b0), .exc_vector,
        .irq_masked(), .exc_taken, .mem_req, .mem_we, .mem_addr,
        .mem_wdata, .mem_rdata, .mem_ack
    );

    always #50 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // Word memory answering one cycle after each request
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (rst_n && mem_req && !mem_ack) begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[mem_addr[11:1]];
            if (mem_we) mem[mem_addr[11:1]] <= mem_wdata;
        end
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            give_verdict();
        end
    end

    task give_verdict();
        if (errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    task chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task do_op(input op_kind_t k, input logic w, input logic [15:0] a,
            input logic [15:0] b);
        do @(negedge sys_clk); while (op_ready !== 1'b1);
        @(posedge sys_clk);
        op_valid <= 1'b1;
        op_kind <= k;
        op_word <= w;
        op_a <= a;
        op_b <= b;
        op_bitn <= b[2:0];
        @(posedge sys_clk);
        op_valid <= 1'b0;
        do @(negedge sys_clk); while (op_done !== 1'b1);
    endtask : do_op

    initial begin
        mem[0] = 16'h0123;
        mem[8] = 16'h0200;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        do @(negedge sys_clk); while (op_ready !== 1'b1);
        chk(next_instruction_pointer, 16'h0122);
        chk({15'h0, condition_flags[7]}, 16'h1);
        @(posedge sys_clk);
        pc_step <= 1'b1;
        sp_load <= 1'b1;
        sp_value <= 16'h0400;
        exc_vector <= 16'h0010;
        @(posedge sys_clk);
        sp_load <= 1'b0;
        pc_step <= 1'b0;
        pc_load <= 1'b1;
        pc_target <= 16'h2345;
        @(negedge sys_clk);
        chk(next_instruction_pointer, 16'h0124);
        @(posedge sys_clk);
        pc_load <= 1'b0;
        @(negedge sys_clk);
        chk(next_instruction_pointer, 16'h2344);
        foreach (rows[i]) begin
            do_op(rows[i].k, rows[i].w, rows[i].a, rows[i].b);
            m = rows[i].w ? 16'hffff : 16'h00ff;
            chk(op_result & m, rows[i].r);
            chk({8'h0, condition_flags}, {8'h0, rows[i].f});
        end
        do_op(OP_LDC, 1'b0, 16'h14, 16'h0);
        @(posedge sys_clk);
        exc_req <= 1'b1;
        do @(negedge sys_clk); while (exc_taken !== 1'b1);
        @(posedge sys_clk);
        exc_req <= 1'b0;
        do @(negedge sys_clk); while (op_ready !== 1'b1);
        chk(mem[11'h1ff], 16'h2344);
        chk(mem[11'h1fe], 16'h1414);
        chk(next_instruction_pointer, 16'h0200);
        chk(stack_top_pointer, 16'h03fc);
        chk({8'h0, condition_flags}, 16'h0094);
        @(posedge sys_clk);
        exc_req <= 1'b1;
        repeat (20) begin
            @(negedge sys_clk);
            seen = seen | exc_taken;
        end
        @(posedge sys_clk);
        exc_req <= 1'b0;
        chk({15'h0, seen}, 16'h0);
        mem[11'h1fe] = 16'h5aa5;
        do_op(OP_RTE, 1'b0, 16'h0, 16'h0);
        chk({8'h0, condition_flags}, 16'h005a);
        chk(next_instruction_pointer, 16'h2344);
        chk(stack_top_pointer, 16'h0400);
        foreach (cs[i]) begin
            @(posedge sys_clk);
            cond_sel <= cs[i];
            @(negedge sys_clk);
            chk({15'h0, cond_true}, {15'h0, ce[i]});
        end
        give_verdict();
    end
endmodule : cpu_flags_core_bench

bind cpu_flags_core cpu_flags_core_sva u_sva (
    .sys_clk, .rst_n, .op_valid, .op_kind, .op_ready, .op_done,
    .condition_flags, .cond_sel, .cond_true, .next_instruction_pointer,
    .stack_top_pointer, .exc_req, .exc_nmi, .irq_masked, .exc_taken,
    .mem_req, .mem_we, .mem_addr
);
